// ---- src/gbes_pkg.sv ----
// shared constants, types and register map of the gpio bank
package gbes_pkg;

	// geometry
	localparam int unsigned PORT_W = 8;
	localparam int unsigned N_PORTS = 4;
	localparam int unsigned N_IO = 3;
	localparam int unsigned ACT_W = 4;
	localparam int unsigned PORT_A = 0;
	localparam int unsigned PORT_B = 1;
	localparam int unsigned PORT_C = 2;
	localparam int unsigned PORT_D = 3;

	// register offsets, index 0 is port a
	localparam logic [7:0] OFF_ACTIVATE = 8'h30;
	localparam logic [N_IO-1:0][7:0] OFF_DIR = {8'hF4, 8'hF0, 8'hE3};
	localparam logic [N_IO-1:0][7:0] OFF_DATA = {8'hF5, 8'hF1, 8'hE4};
	localparam logic [N_IO-1:0][7:0] OFF_INV = {8'hF6, 8'hF2, 8'hE5};
	localparam logic [N_PORTS-1:0][7:0] OFF_STAT = {8'hE9, 8'hE8, 8'hE7, 8'hE6};
	localparam logic [7:0] OFF_IRQ_STAT = 8'hEA;
	localparam logic [7:0] OFF_IRQ_CLR = 8'hEB;
	localparam logic [7:0] OFF_IRQ_EN = 8'hEC;
	localparam logic [7:0] OFF_SUSP = 8'hF3;
	localparam logic [7:0] OFF_FSEL = 8'hF7;

	// reset values
	localparam logic [PORT_W-1:0] RST_DIR = 8'hFF;
	localparam logic [PORT_W-1:0] RST_ZERO = 8'h00;
	localparam logic [ACT_W-1:0] RST_ACT = 4'h0;
	localparam logic [1:0] RST_SUSP = 2'h0;

	// suspend indicator mode field position
	localparam int unsigned SUSP_HI = 7;
	localparam int unsigned SUSP_LO = 6;

	// blink timing: half periods of the two square waves
	localparam longint unsigned CLK_HZ = 64'd20000000;
	localparam longint unsigned MS_PER_S = 64'd1000;
	localparam longint unsigned BLINK_FAST_HALF_MS = 64'd500;
	localparam longint unsigned BLINK_SLOW_HALF_MS = 64'd2000;
	localparam int unsigned BLINK_FAST_HALF_CYC =
		32'(BLINK_FAST_HALF_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned BLINK_SLOW_HALF_CYC =
		32'(BLINK_SLOW_HALF_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned CNT_W = 26;

	// suspend indicator modes in field order
	typedef enum logic [1:0] {
		SUSP_TRI,
		SUSP_LOW,
		SUSP_1HZ,
		SUSP_QHZ
	} gbes_susp_t;

	// one register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} gbes_bus_t;

	// drive of one port: level and output enable
	typedef struct packed {
		logic [PORT_W-1:0] lvl;
		logic [PORT_W-1:0] oe;
	} gbes_drive_t;

endpackage

// ---- src/gbes_edge_det.sv ----
// pin synchroniser and edge detector for one port
`timescale 1ns/1ps
`default_nettype none

module gbes_edge_det
	import gbes_pkg::*;
#(
	parameter int unsigned W = PORT_W
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [W-1:0] i_pins,
	input wire logic i_en,
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_edge
);

	logic [W-1:0] sync1_r, sync1_nxt;
	logic [W-1:0] sync2_r, sync2_nxt;
	logic [W-1:0] prev_r, prev_nxt;

	// two stages before anything looks at the pins; prev tracks even when disabled
	always_comb begin
		sync1_nxt = i_pins;
		sync2_nxt = sync1_r;
		prev_nxt = sync2_r;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r <= prev_nxt;
		end
	end

	// both edge directions count; an inactive port reports none
	assign o_level = sync2_r;
	assign o_edge = (sync2_r ^ prev_r) & {W{i_en}};

endmodule // gbes_edge_det

`default_nettype wire

// ---- src/gbes_top.sv ----
// gpio bank: config registers, pin drive, edge status, suspend indicator
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - direction bit 0 makes pin output, 1 input; all directions reset to inputs.
// - output pins drive the written data bit, which reads back.
// - input pins: data bit reads the pin, writes to it are ignored.
// - inversion bit set complements data against pin, both directions.
// - any rising or falling pin edge sets its event status bit.
// - reading a status register returns it then clears it; writes ignored.
// - status bits seven to zero map to pins seven to zero, all four ports.
// - suspend mode: tri-state, low, 1 Hz or 0.25 Hz 50 percent square.
// - function select 1 puts watchdog (even) or suspend (odd) on port c pin.
// - each port has an activation bit; inactive ports neither drive nor detect, except port c pins with function select 1, which keep their routed drive.

module gbes_top
	import gbes_pkg::*;
#(
	parameter int unsigned BLINK_FAST_HALF = BLINK_FAST_HALF_CYC,
	parameter int unsigned BLINK_SLOW_HALF = BLINK_SLOW_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [PORT_W-1:0] i_port_a_pins,
	output logic [PORT_W-1:0] o_port_a_pins,
	output logic [PORT_W-1:0] o_port_a_pins_oe,
	input wire logic [PORT_W-1:0] i_port_b_pins,
	output logic [PORT_W-1:0] o_port_b_pins,
	output logic [PORT_W-1:0] o_port_b_pins_oe,
	input wire logic [PORT_W-1:0] i_port_c_pins,
	output logic [PORT_W-1:0] o_port_c_pins,
	output logic [PORT_W-1:0] o_port_c_pins_oe,
	input wire logic [PORT_W-1:0] i_port_d_pins,
	input wire logic i_watchdog_timeout_output_n,
	output logic o_suspend_indicator_output,
	output logic o_suspend_indicator_output_oe,
	output logic o_irq
);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	gbes_bus_t bus;
	logic [N_IO-1:0][PORT_W-1:0] dir_r, dir_nxt, data_r, data_nxt, inv_r, inv_nxt;
	logic [N_PORTS-1:0][PORT_W-1:0] stat_r, stat_nxt, pin_lvl, pin_edge, pins_in;
	logic [ACT_W-1:0] act_r, act_nxt;
	logic [1:0] susp_r, susp_nxt;
	logic [PORT_W-1:0] fsel_r, fsel_nxt;
	logic [N_PORTS-1:0] irq_st_r, irq_st_nxt, irq_en_r, irq_en_nxt, port_ev;
	logic [7:0] rdata_r, rdata_nxt;
	gbes_susp_t mode;
	logic [CNT_W-1:0] cnt_r, cnt_nxt, limit;
	logic phase_r, phase_nxt;
	logic susp_lvl, susp_oe;
	gbes_drive_t [N_IO-1:0] drv_r, drv_nxt;
	logic so_lvl_r, so_lvl_nxt, so_oe_r, so_oe_nxt;

	// data view: input bits show the (inverted) pin, output bits the register
	function automatic logic [PORT_W-1:0] io_view(input logic [PORT_W-1:0] dir,
		input logic [PORT_W-1:0] data, input logic [PORT_W-1:0] inv,
		input logic [PORT_W-1:0] lvl);
		return (dir & (lvl ^ inv)) | (~dir & data);
	endfunction

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign pins_in = {i_port_d_pins, i_port_c_pins, i_port_b_pins, i_port_a_pins};

	// one synchroniser and edge detector per port
	for (genvar g = 0; g < N_PORTS; g++) begin : g_edge
		gbes_edge_det #(
			.W(PORT_W)
		) u_edge (
			.i_clk(i_clk),
			.i_nrst(i_nrst),
			.i_pins(pins_in[g]),
			.i_en(act_r[g]),
			.o_level(pin_lvl[g]),
			.o_edge(pin_edge[g])
		);
		assign port_ev[g] = |pin_edge[g];
	end

	// register file next state and read mux
	always_comb begin
		dir_nxt = dir_r;
		data_nxt = data_r;
		inv_nxt = inv_r;
		act_nxt = act_r;
		susp_nxt = susp_r;
		fsel_nxt = fsel_r;
		irq_en_nxt = irq_en_r;
		irq_st_nxt = irq_st_r;
		rdata_nxt = '0;
		if (bus.wr) begin
			for (int i = 0; i < N_IO; i++) begin
				if (bus.addr == OFF_DIR[i]) begin
					dir_nxt[i] = bus.wdata;
				end
				if (bus.addr == OFF_DATA[i]) begin
					data_nxt[i] = (bus.wdata & ~dir_r[i]) | (data_r[i] & dir_r[i]);
				end
				if (bus.addr == OFF_INV[i]) begin
					inv_nxt[i] = bus.wdata;
				end
			end
			if (bus.addr == OFF_ACTIVATE) begin
				act_nxt = bus.wdata[ACT_W-1:0];
			end
			if (bus.addr == OFF_SUSP) begin
				susp_nxt = bus.wdata[SUSP_HI:SUSP_LO];
			end
			if (bus.addr == OFF_FSEL) begin
				fsel_nxt = bus.wdata;
			end
			if (bus.addr == OFF_IRQ_EN) begin
				irq_en_nxt = bus.wdata[N_PORTS-1:0];
			end
			if (bus.addr == OFF_IRQ_CLR) begin
				irq_st_nxt = irq_st_r & ~bus.wdata[N_PORTS-1:0];
			end
		end
		// new port events beat a clear in the same cycle
		irq_st_nxt = irq_st_nxt | port_ev;
		if (bus.rd) begin
			for (int i = 0; i < N_IO; i++) begin
				if (bus.addr == OFF_DIR[i]) begin
					rdata_nxt = dir_r[i];
				end
				if (bus.addr == OFF_DATA[i]) begin
					rdata_nxt = io_view(dir_r[i], data_r[i], inv_r[i], pin_lvl[i]);
				end
				if (bus.addr == OFF_INV[i]) begin
					rdata_nxt = inv_r[i];
				end
			end
			for (int j = 0; j < N_PORTS; j++) begin
				if (bus.addr == OFF_STAT[j]) begin
					rdata_nxt = stat_r[j];
				end
			end
			if (bus.addr == OFF_ACTIVATE) begin
				rdata_nxt = 8'(act_r);
			end
			if (bus.addr == OFF_SUSP) begin
				rdata_nxt[SUSP_HI:SUSP_LO] = susp_r;
			end
			if (bus.addr == OFF_FSEL) begin
				rdata_nxt = fsel_r;
			end
			if (bus.addr == OFF_IRQ_STAT) begin
				rdata_nxt = 8'(irq_st_r);
			end
			if (bus.addr == OFF_IRQ_EN) begin
				rdata_nxt = 8'(irq_en_r);
			end
		end
	end

	// status next state: writes never reach these
	always_comb begin
		for (int j = 0; j < N_PORTS; j++) begin
			stat_nxt[j] = stat_r[j];
			if (bus.rd && bus.addr == OFF_STAT[j]) begin
				stat_nxt[j] = '0;
			end
			stat_nxt[j] = stat_nxt[j] | pin_edge[j];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			dir_r <= {N_IO{RST_DIR}};
			data_r <= {N_IO{RST_ZERO}};
			inv_r <= {N_IO{RST_ZERO}};
			stat_r <= {N_PORTS{RST_ZERO}};
			act_r <= RST_ACT;
			susp_r <= RST_SUSP;
			fsel_r <= RST_ZERO;
			irq_en_r <= '0;
			irq_st_r <= '0;
			rdata_r <= RST_ZERO;
		end else begin
			dir_r <= dir_nxt;
			data_r <= data_nxt;
			inv_r <= inv_nxt;
			stat_r <= stat_nxt;
			act_r <= act_nxt;
			susp_r <= susp_nxt;
			fsel_r <= fsel_nxt;
			irq_en_r <= irq_en_nxt;
			irq_st_r <= irq_st_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_irq = |(irq_st_r & irq_en_r);

	// blink counter; reaching the limit also catches a shorter limit after a mode change
	assign mode = gbes_susp_t'(susp_r);
	always_comb begin
		limit = (mode == SUSP_QHZ) ? CNT_W'(BLINK_SLOW_HALF - 1) : CNT_W'(BLINK_FAST_HALF - 1);
		cnt_nxt = '0;
		phase_nxt = 1'b0;
		susp_lvl = 1'b0;
		susp_oe = 1'b0;
		case (mode)
			SUSP_TRI: begin
				susp_oe = 1'b0;
			end
			SUSP_LOW: begin
				susp_oe = 1'b1;
			end
			SUSP_1HZ, SUSP_QHZ: begin
				susp_oe = 1'b1;
				susp_lvl = phase_r;
				if (cnt_r >= limit) begin
					phase_nxt = ~phase_r;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
					phase_nxt = phase_r;
				end
			end
			default: begin
				susp_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cnt_r <= '0;
			phase_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	// pin drive; registered so pins never glitch on decode
	always_comb begin
		for (int i = 0; i < N_IO; i++) begin
			drv_nxt[i].lvl = data_r[i] ^ inv_r[i];
			drv_nxt[i].oe = ~dir_r[i] & {PORT_W{act_r[i]}};
		end
		for (int k = 0; k < PORT_W; k++) begin
			if (fsel_r[k]) begin
				if (k % 2 == 0) begin
					drv_nxt[PORT_C].lvl[k] = i_watchdog_timeout_output_n;
					drv_nxt[PORT_C].oe[k] = 1'b1;
				end else begin
					drv_nxt[PORT_C].lvl[k] = susp_lvl;
					drv_nxt[PORT_C].oe[k] = susp_oe;
				end
			end
		end
		so_lvl_nxt = susp_lvl;
		so_oe_nxt = susp_oe;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			drv_r <= '0;
			so_lvl_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			drv_r <= drv_nxt;
			so_lvl_r <= so_lvl_nxt;
			so_oe_r <= so_oe_nxt;
		end
	end

	assign o_port_a_pins = drv_r[PORT_A].lvl;
	assign o_port_a_pins_oe = drv_r[PORT_A].oe;
	assign o_port_b_pins = drv_r[PORT_B].lvl;
	assign o_port_b_pins_oe = drv_r[PORT_B].oe;
	assign o_port_c_pins = drv_r[PORT_C].lvl;
	assign o_port_c_pins_oe = drv_r[PORT_C].oe;
	assign o_suspend_indicator_output = so_lvl_r;
	assign o_suspend_indicator_output_oe = so_oe_r;

	// checks
	sequence s_stat_read;
		bus.rd && bus.addr == OFF_STAT[PORT_B] && pin_edge[PORT_B] == '0;
	endsequence

	sequence s_data_write;
		bus.wr && bus.addr == OFF_DATA[PORT_A];
	endsequence

	sequence s_mode_held(gbes_susp_t m);
		(mode == m) [*2];
	endsequence

	chk_dir_reset_in: assert property (
		$rose(i_nrst) |-> (dir_r == {N_IO{RST_DIR}}) && o_port_a_pins_oe == '0)
		else $error("direction not all inputs after reset");

	chk_input_no_drive: assert property (
		1'b1 |=> ((o_port_b_pins_oe & $past(dir_r[PORT_B])) == '0))
		else $error("input pin driven");

	chk_data_write_out: assert property (
		s_data_write ##1 !bus.wr |=> ((o_port_a_pins & ~$past(dir_r[PORT_A], 2))
			== (($past(i_wdata, 2) ^ inv_r[PORT_A]) & ~$past(dir_r[PORT_A], 2))))
		else $error("written data not on output pin");

	chk_input_write_ign: assert property (
		s_data_write |=> ((data_r[PORT_A] & $past(dir_r[PORT_A]))
			== ($past(data_r[PORT_A]) & $past(dir_r[PORT_A]))))
		else $error("write changed an input data bit");

	chk_edge_sets_stat: assert property (
		pin_edge[PORT_A][0] |=> stat_r[PORT_A][0])
		else $error("edge did not set status");

	chk_read_clears: assert property (
		s_stat_read |=> stat_r[PORT_B] == '0 && o_rdata == $past(stat_r[PORT_B]))
		else $error("status read did not return then clear");

	chk_read_edge_kept: assert property (
		bus.rd && bus.addr == OFF_STAT[PORT_D] && pin_edge[PORT_D][7]
			|=> stat_r[PORT_D][7])
		else $error("edge lost in read-clear cycle");

	chk_susp_low: assert property (
		s_mode_held(SUSP_LOW) |=> o_suspend_indicator_output_oe
			&& !o_suspend_indicator_output)
		else $error("suspend indicator not driven low");

	chk_susp_tri: assert property (
		s_mode_held(SUSP_TRI) |=> !o_suspend_indicator_output_oe)
		else $error("suspend indicator not released");

	chk_fsel_watchdog: assert property (
		fsel_r[0] |=> o_port_c_pins_oe[0]
			&& o_port_c_pins[0] == $past(i_watchdog_timeout_output_n))
		else $error("watchdog output not routed to port c");

	chk_inactive_quiet: assert property (
		!act_r[PORT_A] |=> o_port_a_pins_oe == '0 && $past(pin_edge[PORT_A]) == '0)
		else $error("inactive port drives or detects");

endmodule // gbes_top

`default_nettype wire

// ---- verification/gbes_board.sv ----
// board side of the gpio pins
`timescale 1ns/1ps
`default_nettype none

module gbes_board
	import gbes_pkg::*;
(
	input wire gbes_drive_t i_drv [N_IO],
	input wire logic [N_PORTS-1:0][PORT_W-1:0] i_ext,
	output logic [N_PORTS-1:0][PORT_W-1:0] o_pin
);
	// driven pins show the device level, released ones the board's own level
	for (genvar k = 0; k < N_IO; k++) begin : g_io
		assign o_pin[k] = (i_drv[k].oe & i_drv[k].lvl) | (~i_drv[k].oe & i_ext[k]);
	end
	// port d has no drive path in this block
	assign o_pin[PORT_D] = i_ext[PORT_D];
endmodule // gbes_board

`default_nettype wire

// ---- verification/gbes_bench.sv ----
// self-checking bench of the gpio bank
`timescale 1ns/1ps
`default_nettype none

module gbes_bench
	import gbes_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic wd_n = 1'b1;
	logic [3:0][7:0] ext = '0;
	logic [3:0][7:0] pin;
	logic [7:0] rdata;
	gbes_drive_t drv [N_IO];
	logic sus;
	logic sus_oe;
	logic irq;
	int bad_count = 0;
	int total_checks = 0;

	// short blink counts keep the run brief
	gbes_top #(.BLINK_FAST_HALF(4), .BLINK_SLOW_HALF(16)) i_dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_port_a_pins(pin[0]), .o_port_a_pins(drv[0].lvl), .o_port_a_pins_oe(drv[0].oe),
		.i_port_b_pins(pin[1]), .o_port_b_pins(drv[1].lvl), .o_port_b_pins_oe(drv[1].oe),
		.i_port_c_pins(pin[2]), .o_port_c_pins(drv[2].lvl), .o_port_c_pins_oe(drv[2].oe),
		.i_port_d_pins(pin[3]), .i_watchdog_timeout_output_n(wd_n),
		.o_suspend_indicator_output(sus), .o_suspend_indicator_output_oe(sus_oe),
		.o_irq(irq)
	);

	gbes_board i_board (.i_drv(drv), .i_ext(ext), .o_pin(pin));

	// clock generation
	always #25 i_clk = ~i_clk;

	// compare and count
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// one-cycle write strobe
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1 chk(nm, e, rdata);
	endtask

	// defaults after reset and an unmapped place
	task automatic t_reset();
		rchk("dir a", OFF_DIR[0], 8'hFF);
		rchk("dir b", OFF_DIR[1], 8'hFF);
		rchk("dir c", OFF_DIR[2], 8'hFF);
		rchk("data c", OFF_DATA[2], 8'h00);
		rchk("inv a", OFF_INV[0], 8'h00);
		rchk("stat d", OFF_STAT[3], 8'h00);
		rchk("fsel", OFF_FSEL, 8'h00);
		rchk("act", OFF_ACTIVATE, 8'h00);
		wrr(8'hE0, 8'h5A);
		rchk("unmapped", 8'hE0, 8'h00);
		chk("oe a", 8'h00, drv[0].oe);
	endtask

	// mixed directions on port c, then inverted
	task automatic t_out();
		wrr(OFF_ACTIVATE, 8'h0F);
		ext[2] <= 8'h3C;
		wrr(OFF_DIR[2], 8'hF0);
		wrr(OFF_DATA[2], 8'hA5);
		repeat (3) @(posedge i_clk);
		#1 chk("oe c", 8'h0F, drv[2].oe);
		chk("pin c", 8'h05, pin[2] & 8'h0F);
		rchk("data c mix", OFF_DATA[2], 8'h35);
		wrr(OFF_INV[2], 8'hFF);
		repeat (3) @(posedge i_clk);
		#1 chk("pin c inv", 8'h0A, pin[2] & 8'h0F);
		rchk("data c inv", OFF_DATA[2], 8'hC5);
		wrr(OFF_INV[2], 8'h00);
		wrr(OFF_DIR[2], 8'hFF);
	endtask

	// edge status, read-clear and the interrupt
	task automatic t_edge();
		repeat (6) @(posedge i_clk);
		wrr(OFF_IRQ_CLR, 8'h0F);
		// the drive and inversion changes of t_out toggled bits 3:0 as well
		rchk("stat c", OFF_STAT[2], 8'h3F);
		wrr(OFF_IRQ_EN, 8'h01);
		ext[0] <= 8'h81;
		ext[3] <= 8'h3C;
		repeat (6) @(posedge i_clk);
		#1 chk("irq", 8'h01, {7'h00, irq});
		rchk("stat a", OFF_STAT[0], 8'h81);
		rchk("stat a rc", OFF_STAT[0], 8'h00);
		rchk("stat b", OFF_STAT[1], 8'h00);
		wrr(OFF_STAT[3], 8'h00);
		// the new edge reaches the detector in the very cycle of the read strobe
		ext[3] <= 8'hBC;
		@(posedge i_clk);
		rchk("stat d", OFF_STAT[3], 8'h3C);
		rchk("stat d kept", OFF_STAT[3], 8'h80);
		rchk("irq stat", OFF_IRQ_STAT, 8'h09);
		wrr(OFF_IRQ_CLR, 8'h0F);
		@(posedge i_clk);
		#1 chk("irq clr", 8'h00, {7'h00, irq});
		wrr(OFF_IRQ_EN, 8'h00);
		ext[0] <= 8'h00;
		repeat (6) @(posedge i_clk);
		#1 chk("irq mask", 8'h00, {7'h00, irq});
		rchk("stat a fall", OFF_STAT[0], 8'h81);
	endtask

	// an inactive port neither drives nor reports
	task automatic t_idle();
		wrr(OFF_ACTIVATE, 8'h0D);
		ext[1] <= 8'hFF;
		wrr(OFF_DIR[1], 8'h00);
		repeat (6) @(posedge i_clk);
		#1 chk("oe b idle", 8'h00, drv[1].oe);
		rchk("stat b idle", OFF_STAT[1], 8'h00);
		// reactivated: port b drives every pin, port a only its upper nibble
		wrr(OFF_ACTIVATE, 8'h0F);
		wrr(OFF_DATA[1], 8'hC3);
		wrr(OFF_DIR[0], 8'h0F);
		wrr(OFF_DATA[0], 8'h96);
		repeat (3) @(posedge i_clk);
		#1 chk("oe b on", 8'hFF, drv[1].oe);
		chk("pin b", 8'hC3, drv[1].lvl);
		chk("oe a out", 8'hF0, drv[0].oe);
		chk("pin a", 8'h90, drv[0].lvl);
		wrr(OFF_DIR[1], 8'hFF);
		wrr(OFF_DIR[0], 8'hFF);
	endtask

	// one suspend mode; a bounded wait guards each level change
	task automatic t_susp(input logic [1:0] m, input logic oe, input int half);
		int n;
		logic v;
		wrr(OFF_SUSP, {m, 6'h3F});
		rchk("susp rd", OFF_SUSP, {m, 6'h00});
		chk("susp oe", {7'h00, oe}, {7'h00, sus_oe});
		if (half == 0) begin
			chk("susp lvl", 8'h00, {7'h00, sus & oe});
		end else begin
			for (int k = 0; k < 2; k++) begin
				v = sus;
				n = 0;
				while (sus === v && n < 100) begin
					@(posedge i_clk);
					#1 n++;
				end
			end
			chk("half period", half[7:0], n[7:0]);
		end
	endtask

	// every port c pin routed: even to watchdog, odd to the low indicator
	task automatic t_fsel();
		wrr(OFF_SUSP, 8'h40);
		wrr(OFF_FSEL, 8'hFF);
		repeat (3) @(posedge i_clk);
		#1 chk("fsel oe", 8'hFF, drv[2].oe);
		chk("fsel lvl", 8'h55, drv[2].lvl);
		@(posedge i_clk);
		wd_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1 chk("fsel wd", 8'h00, drv[2].lvl);
		wrr(OFF_FSEL, 8'h00);
		repeat (3) @(posedge i_clk);
		#1 chk("fsel off", 8'h00, drv[2].oe);
	endtask

	// verdict and end of run
	task automatic summarize();
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		t_reset();
		t_out();
		t_edge();
		t_idle();
		t_susp(2'h0, 1'b0, 0);
		t_susp(2'h1, 1'b1, 0);
		t_susp(2'h2, 1'b1, 4);
		t_susp(2'h3, 1'b1, 16);
		t_fsel();
		summarize();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		summarize();
	end
endmodule // gbes_bench

`default_nettype wire
